// ==== logic/cat_pkg.sv ====
`default_nettype none

package cat_pkg;

  // -------------------------------------------------------------
  // register addresses on the special function register port
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'hd8;
  localparam logic [7:0] ADDR_COUNTER_MODE = 8'hd9;

  // -------------------------------------------------------------
  // field positions, control and flag register
  // -------------------------------------------------------------
  localparam int CCTL_OVERFLOW_FLAG = 7;
  localparam int CCTL_RUN = 6;
  localparam int CCTL_MOD_FLAGS_LO = 0;
  localparam int NUM_MODULES = 5;

  // -------------------------------------------------------------
  // field positions, counter mode register
  // -------------------------------------------------------------
  localparam int ARRAY_COUNTER_MODE_IDLE_GATE = 7;
  localparam int ARRAY_COUNTER_MODE_WDT_ENABLE = 6;
  localparam int ARRAY_COUNTER_MODE_SRC_HI = 2;
  localparam int ARRAY_COUNTER_MODE_SRC_LO = 1;
  localparam int ARRAY_COUNTER_MODE_OVF_IRQ_EN = 0;

  // -------------------------------------------------------------
  // reset values and read masks (unimplemented bits read zero)
  // -------------------------------------------------------------
  localparam logic [7:0] CCTL_RESET = 8'h00;
  localparam logic [7:0] ARRAY_COUNTER_MODE_RESET = 8'h00;
  localparam logic [7:0] CCTL_READ_MASK = 8'hdf;
  localparam logic [7:0] ARRAY_COUNTER_MODE_READ_MASK = 8'hc7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // -------------------------------------------------------------
  // count source encodings
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_OSC_SLOW = 2'h0,
    SRC_OSC_FAST = 2'h1,
    SRC_TIMER0 = 2'h2,
    SRC_EXTERNAL = 2'h3
  } cat_source_type;

  // -------------------------------------------------------------
  // oscillator divisors, normal and double-speed
  // -------------------------------------------------------------
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_SLOW_X2 = 4'h6;
  localparam logic [3:0] DIV_FAST_X2 = 4'h2;

  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

endpackage

`default_nettype wire

// ==== logic/cat_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none

module cat_prescaler (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic fast_sel_i,
  input wire logic double_speed_i,
  output logic tick_o
);

  logic [3:0] div_cnt_reg;
  logic [3:0] div_last;

  // pick the divisor for the selected oscillator tap
  function automatic logic [3:0] last_count(input logic fast,
                                            input logic x2);
    logic [3:0] div;
    div = fast ? (x2 ? cat_pkg::DIV_FAST_X2 : cat_pkg::DIV_FAST)
               : (x2 ? cat_pkg::DIV_SLOW_X2 : cat_pkg::DIV_SLOW);
    return div - 4'h1;
  endfunction

  assign div_last = last_count(fast_sel_i, double_speed_i);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (div_cnt_reg >= div_last) begin
      // >= so a divisor change mid-period never overruns
      div_cnt_reg <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      tick_o <= 1'b0;
    end
  end

  a_tick_single: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    tick_o |=> !tick_o)
    else $error("prescaler tick lasted more than one cycle");

endmodule

`default_nettype wire

// ==== logic/cat_time_base.sv ====
// Behaviour
// - one shared 16-bit counter for five modules
// - source select: osc/12, osc/4, timer0, pin
// - double speed halves both oscillator divisors
// - idle gate bit stops counting during idle
// - watchdog enable bit drives module 4 watchdog
// - overflow interrupt only when its enable set
// - run bit six starts and stops counting
// - overflow flag bit seven, software-only clear
// - module flags bits 0-4, software-only clear
// - module events may each request an interrupt
// - all requests share one interrupt output
// - count pin and module pins shared with port
`timescale 1ns/1ps
`default_nettype none

module cat_time_base (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic double_speed_mode_i,
  input wire logic idle_mode_i,
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  input wire logic [4:0] module_event_i,
  input wire logic [4:0] module_irq_enable_i,
  input wire logic [4:0] module_pin_used_i,
  output logic [15:0] counter_value_o,
  output logic count_tick_o,
  output logic watchdog_enable_bit_o,
  output logic irq_o,
  output logic [5:0] port1_array_owned_o
);

  // -------------------------------------------------------------
  // register state
  // -------------------------------------------------------------
  logic overflow_flag_reg;
  logic run_control_bit_reg;
  logic [4:0] module_flags_reg;
  logic idle_gate_bit_reg;
  logic watchdog_enable_bit_reg;
  logic [1:0] count_source_reg;
  logic overflow_irq_enable_reg;
  logic [15:0] count_reg;

  logic wr_cctl;
  logic wr_array_counter_mode;
  logic osc_tick;
  logic count_pulse;
  logic count_enable;
  logic count_step;
  logic wrap;

  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic ext_fall;

  // true when the module asks for an interrupt on flag f with enable e
  function automatic logic any_request(input logic [4:0] f,
                                       input logic [4:0] e);
    return |(f & e);
  endfunction

  assign wr_cctl = sfr_wr_i && (sfr_addr_i == cat_pkg::ADDR_CONTROL_FLAGS);
  assign wr_array_counter_mode = sfr_wr_i && (sfr_addr_i == cat_pkg::ADDR_COUNTER_MODE);

  // -------------------------------------------------------------
  // count source
  // -------------------------------------------------------------
  cat_prescaler u_prescaler (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .fast_sel_i(count_source_reg == cat_pkg::SRC_OSC_FAST),
    .double_speed_i(double_speed_mode_i),
    .tick_o(osc_tick)
  );

  // pin is asynchronous; two flops before the edge detector
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= external_count_input_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // slow pin assumed
  // sampling catches each falling edge only if the pin is this slow
  assign ext_fall = ext_prev_reg && !ext_sync_reg;

  always_comb begin
    unique case (cat_pkg::cat_source_type'(count_source_reg))
      cat_pkg::SRC_OSC_SLOW: count_pulse = osc_tick;
      cat_pkg::SRC_OSC_FAST: count_pulse = osc_tick;
      cat_pkg::SRC_TIMER0: count_pulse = timer0_overflow_i;
      cat_pkg::SRC_EXTERNAL: count_pulse = ext_fall;
    endcase
  end

  assign count_enable = run_control_bit_reg &&
                        !(idle_gate_bit_reg && idle_mode_i);
  assign count_step = count_enable && count_pulse;
  assign wrap = count_step && (count_reg == cat_pkg::COUNT_MAX);

  // -------------------------------------------------------------
  // shared 16-bit counter
  // -------------------------------------------------------------
  // common time base
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      count_reg <= cat_pkg::COUNT_RESET;
    end else if (count_step) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      counter_value_o <= cat_pkg::COUNT_RESET;
      count_tick_o <= 1'b0;
    end else begin
      counter_value_o <= count_step ? count_reg + 16'h0001 : count_reg;
      count_tick_o <= count_step;
    end
  end

  // -------------------------------------------------------------
  // control and flag register
  // -------------------------------------------------------------
  // overflow flag, set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      overflow_flag_reg <= cat_pkg::CCTL_RESET[cat_pkg::CCTL_OVERFLOW_FLAG];
    end else begin
      overflow_flag_reg <= wrap ||
        (wr_cctl ? sfr_wdata_i[cat_pkg::CCTL_OVERFLOW_FLAG]
                 : overflow_flag_reg);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      run_control_bit_reg <= cat_pkg::CCTL_RESET[cat_pkg::CCTL_RUN];
    end else if (wr_cctl) begin
      run_control_bit_reg <= sfr_wdata_i[cat_pkg::CCTL_RUN];
    end
  end

  // module flags, set wins over clear
  // each module function sets its flag
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      module_flags_reg <= cat_pkg::CCTL_RESET[4:0];
    end else begin
      module_flags_reg <= module_event_i |
        (wr_cctl ? sfr_wdata_i[cat_pkg::CCTL_MOD_FLAGS_LO +: 5]
                 : module_flags_reg);
    end
  end

  // -------------------------------------------------------------
  // counter mode register
  // -------------------------------------------------------------
  // idle gate, watchdog enable, source and overflow interrupt enable fields
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      idle_gate_bit_reg <= cat_pkg::ARRAY_COUNTER_MODE_RESET[cat_pkg::ARRAY_COUNTER_MODE_IDLE_GATE];
      watchdog_enable_bit_reg <=
        cat_pkg::ARRAY_COUNTER_MODE_RESET[cat_pkg::ARRAY_COUNTER_MODE_WDT_ENABLE];
      count_source_reg <= cat_pkg::ARRAY_COUNTER_MODE_RESET[2:1];
      overflow_irq_enable_reg <=
        cat_pkg::ARRAY_COUNTER_MODE_RESET[cat_pkg::ARRAY_COUNTER_MODE_OVF_IRQ_EN];
    end else if (wr_array_counter_mode) begin
      idle_gate_bit_reg <= sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_IDLE_GATE];
      watchdog_enable_bit_reg <= sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_WDT_ENABLE];
      count_source_reg <= {sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_SRC_HI],
                           sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_SRC_LO]};
      overflow_irq_enable_reg <= sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_OVF_IRQ_EN];
    end
  end

  assign watchdog_enable_bit_o = watchdog_enable_bit_reg;

  // -------------------------------------------------------------
  // read port, shared interrupt, pin ownership
  // -------------------------------------------------------------
  // unimplemented bits
  // reads return zero there; what software writes there is dropped
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= cat_pkg::UNMAPPED_READ;
    end else if (sfr_rd_i) begin
      if (sfr_addr_i == cat_pkg::ADDR_CONTROL_FLAGS) begin
        sfr_rdata_o <= {overflow_flag_reg, run_control_bit_reg, 1'b0,
                        module_flags_reg} & cat_pkg::CCTL_READ_MASK;
      end else if (sfr_addr_i == cat_pkg::ADDR_COUNTER_MODE) begin
        sfr_rdata_o <= {idle_gate_bit_reg, watchdog_enable_bit_reg,
                        3'h0, count_source_reg, overflow_irq_enable_reg}
                       & cat_pkg::ARRAY_COUNTER_MODE_READ_MASK;
      end else begin
        sfr_rdata_o <= cat_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (overflow_flag_reg && overflow_irq_enable_reg) ||
               any_request(module_flags_reg, module_irq_enable_i);
    end
  end

  // pin sharing
  // a pin not claimed here stays ordinary port i/o
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port1_array_owned_o <= 6'h00;
    end else begin
      port1_array_owned_o <= {module_pin_used_i,
        count_source_reg == cat_pkg::SRC_EXTERNAL};
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_wrap_sets_flag: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wrap |=> overflow_flag_reg && (count_reg == 16'h0000))
    else $error("wrap did not set overflow flag");

  a_flag_sticky: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    overflow_flag_reg && !wr_cctl |=> overflow_flag_reg)
    else $error("overflow flag cleared without a write");

  a_count_step: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    count_step |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not advance by one");

  a_stopped_holds: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !run_control_bit_reg |=> $stable(count_reg))
    else $error("counter moved while stopped");

  a_idle_gated: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    idle_gate_bit_reg && idle_mode_i |=> $stable(count_reg))
    else $error("counter moved in gated idle");

  a_mod_flag_set: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    module_event_i[0] |=> module_flags_reg[0] ##1 irq_o ||
                          !module_irq_enable_i[0])
    else $error("module event lost");

  a_irq_masked: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !overflow_irq_enable_reg && module_flags_reg == 5'h00 |=> !irq_o)
    else $error("interrupt with overflow disabled");

  a_wdt_follows: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wr_array_counter_mode |=> watchdog_enable_bit_o ==
                $past(sfr_wdata_i[cat_pkg::ARRAY_COUNTER_MODE_WDT_ENABLE]))
    else $error("watchdog enable did not follow write");

  a_shared_irq: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    overflow_flag_reg && overflow_irq_enable_reg |=> irq_o)
    else $error("overflow request missing on shared line");

endmodule

`default_nettype wire

// ==== testbench/cat_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module cat_pin_model (
  input wire logic core_clk_i,
  input wire logic enable_i,
  output logic pin_o,
  output logic [7:0] falls_o
);
  logic [1:0] phase_reg;

  initial begin
    pin_o = 1'b1;
    falls_o = 8'h00;
    phase_reg = 2'h0;
  end

  // ---------------------------------------------------------
  // count pin driver
  // ---------------------------------------------------------
  // rate limit
  // toggles every 4 clocks, the fastest legal rate; the pin is parked
  // at the pulled-up port level outside bursts
  always @(posedge core_clk_i) begin
    if (!enable_i) begin
      pin_o <= #1 1'b1;
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) begin
        pin_o <= #1 !pin_o;
        if (pin_o) begin
          falls_o <= #1 falls_o + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== testbench/test_counter_array_time_base.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_counter_array_time_base;
  logic core_clk_i, sys_rst_i, sfr_wr_i, sfr_rd_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic double_speed_mode_i, idle_mode_i, timer0_overflow_i, ext_pin;
  logic [4:0] module_event_i, module_irq_enable_i, module_pin_used_i;
  logic [15:0] counter_value_o;
  logic count_tick_o, watchdog_enable_bit_o, irq_o, pin_en;
  logic [5:0] port1_array_owned_o;
  logic [7:0] falls;
  int failures, checked, i, k, c, div, f0;
  logic [15:0] v;

  cat_time_base dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .double_speed_mode_i(double_speed_mode_i), .idle_mode_i(idle_mode_i),
    .timer0_overflow_i(timer0_overflow_i),
    .external_count_input_i(ext_pin), .module_event_i(module_event_i),
    .module_irq_enable_i(module_irq_enable_i),
    .module_pin_used_i(module_pin_used_i),
    .counter_value_o(counter_value_o), .count_tick_o(count_tick_o),
    .watchdog_enable_bit_o(watchdog_enable_bit_o), .irq_o(irq_o),
    .port1_array_owned_o(port1_array_owned_o));

  cat_pin_model pins (.core_clk_i(core_clk_i), .enable_i(pin_en),
    .pin_o(ext_pin), .falls_o(falls));

  // ---------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i) #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    step(1);
    sfr_wr_i = 1'b0;
    // one idle edge so a following write never re-raises in this step
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    step(1);
    sfr_rd_i = 1'b0;
    step(1);
    check({8'h00, sfr_rdata_o}, {8'h00, exp});
  endtask

  task automatic ticks(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      step(1);
      if (count_tick_o === 1'b1) cnt++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = !core_clk_i;
  end

  // ---------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------
  initial begin
    failures = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = '0;
    {double_speed_mode_i, idle_mode_i, timer0_overflow_i, pin_en} = '0;
    {module_event_i, module_irq_enable_i, module_pin_used_i} = '0;
    step(10);
    sys_rst_i = 1'b0;
    rd(cat_pkg::ADDR_CONTROL_FLAGS, cat_pkg::CCTL_RESET);
    rd(cat_pkg::ADDR_COUNTER_MODE, cat_pkg::ARRAY_COUNTER_MODE_RESET);
    rd(8'h00, cat_pkg::UNMAPPED_READ);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'hc7);
    rd(cat_pkg::ADDR_COUNTER_MODE, 8'hc7);
    check({15'h0, watchdog_enable_bit_o}, 16'h1);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h00);
    check({15'h0, watchdog_enable_bit_o}, 16'h0);
    $display("test registers done");
    wr(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
    rd(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
    for (i = 0; i < 4; i++) begin
      wr(cat_pkg::ADDR_COUNTER_MODE, {6'h0, i[0], 1'b0});
      double_speed_mode_i = i[1];
      div = i[1] ? (i[0] ? cat_pkg::DIV_FAST_X2 : cat_pkg::DIV_SLOW_X2)
                 : (i[0] ? cat_pkg::DIV_FAST : cat_pkg::DIV_SLOW);
      step(30);
      v = counter_value_o;
      ticks(120, c);
      check(16'(c), 16'(120 / div));
      check(counter_value_o - v, 16'(c));
    end
    double_speed_mode_i = 1'b0;
    $display("test internal sources done");
    idle_mode_i = 1'b1;
    ticks(120, c);
    check(16'(c), 16'd30);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h82);
    step(4);
    ticks(120, c);
    check(16'(c), 16'd0);
    idle_mode_i = 1'b0;
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h02);
    wr(cat_pkg::ADDR_CONTROL_FLAGS, 8'h00);
    step(4);
    ticks(120, c);
    check(16'(c), 16'd0);
    $display("test gating done");
    wr(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h04);
    step(3);
    v = counter_value_o;
    repeat (5) begin
      timer0_overflow_i = 1'b1;
      step(1);
      timer0_overflow_i = 1'b0;
      step(2);
    end
    step(3);
    check(counter_value_o, v + 16'd5);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h06);
    check({10'h0, port1_array_owned_o}, 16'h0001);
    f0 = falls;
    v = counter_value_o;
    pin_en = 1'b1;
    ticks(80, c);
    pin_en = 1'b0;
    ticks(10, k);
    check(16'(c + k), 16'(falls - f0));
    check(counter_value_o - v, 16'(c + k));
    module_pin_used_i = 5'h15;
    step(2);
    check({10'h0, port1_array_owned_o}, 16'h002b);
    module_pin_used_i = 5'h00;
    $display("test external sources done");
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h04);
    timer0_overflow_i = 1'b1;
    for (k = 0; k < 70000 && counter_value_o !== 16'hffff; k++) step(1);
    // the wrap needs one more counted pulse once ffff shows
    step(1);
    timer0_overflow_i = 1'b0;
    if (k == 70000) failures++;
    step(5);
    check({15'h0, irq_o}, 16'h0);
    rd(cat_pkg::ADDR_CONTROL_FLAGS, 8'hc0);
    check(counter_value_o, cat_pkg::COUNT_RESET);
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'h05);
    step(2);
    check({15'h0, irq_o}, 16'h1);
    wr(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
    step(2);
    check({15'h0, irq_o}, 16'h0);
    rd(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
    $display("test overflow done");
    for (i = 0; i < cat_pkg::NUM_MODULES; i++) begin
      module_event_i = 5'(1 << i);
      step(1);
      module_event_i = 5'h00;
      step(4);
      rd(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40 | 8'(1 << i));
      check({15'h0, irq_o}, 16'h0);
      module_irq_enable_i = 5'(1 << i);
      step(2);
      check({15'h0, irq_o}, 16'h1);
      wr(cat_pkg::ADDR_CONTROL_FLAGS, 8'h40);
      step(2);
      check({15'h0, irq_o}, 16'h0);
      module_irq_enable_i = 5'h00;
    end
    $display("test module flags done");
    wr(cat_pkg::ADDR_COUNTER_MODE, 8'hc5);
    sys_rst_i = 1'b1;
    step(2);
    sys_rst_i = 1'b0;
    check({15'h0, watchdog_enable_bit_o}, 16'h0);
    rd(cat_pkg::ADDR_CONTROL_FLAGS, cat_pkg::CCTL_RESET);
    rd(cat_pkg::ADDR_COUNTER_MODE, cat_pkg::ARRAY_COUNTER_MODE_RESET);
    $display("test second reset done");
    finish_test;
  end
endmodule

`default_nettype wire
